//--- reset_irq_ack.sv
// Reset entry, interrupt sampling and acknowledge strobe logic
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE1] Reset taken asynchronously, may start cycle late
// [RULE2] Processor mode: two vector fetches, seven waits
// [RULE3] Computer mode: two vector fetches, zero waits
// [RULE4] Flag, serial, timer pins are reset-floated pins
// [RULE5] Reset low floats every reset-floated pin
// [RULE6] Direction outputs float throughout reset
// [RULE7] Reset loads bus wait states to seven
// [RULE8] Request lines are level sensitive, active low
// [RULE9] Requests sampled at first phase falling edge
// [RULE10] Core and DMA take requests at fetch boundaries
// [RULE11] Requester holds line one to two edges
// [RULE12] Same line accepted every two phase cycles; code re-accepts a held line at every phase one fall
// [RULE13] Requests taken asynchronously, may lag a cycle
// [RULE14] Strobe low at decode, high at read
// [RULE15] Strobe low exactly one cycle, despite stretch
// [RULE16] Detected request pending until taken, then cleared
module reset_irq_ack #(
    parameter int IRQ_N   = reset_irq_pkg::IRQ_LINES,
    parameter int ASYNC_N = reset_irq_pkg::ASYNC_PINS,
    parameter int RW_N    = reset_irq_pkg::RW_PINS
) (
    input  wire logic                  i_ref_clk,     // 100 MHz clock
    input  wire logic                  i_arst_n,      // Async reset pin
    input  wire logic                  i_ce,          // Clock enable
    input  wire logic                  i_mcu_mode,    // Strap: on-chip boot
    input  wire logic [IRQ_N-1:0]      i_ext_irq_n,   // Request pins
    input  wire reset_irq_pkg::take_type i_take,      // Take from core/DMA
    input  wire logic                  i_ack_decode,  // Ack instr decoding
    input  wire logic                  i_bus_ws_wr,   // Rewrite wait states
    input  wire logic [2:0]            i_bus_ws_data, // New wait states
    input  wire logic [ASYNC_N-1:0]    i_async_oe_req, // Units want to drive
    input  wire logic [RW_N-1:0]       i_rw_oe_req,   // Direction drive req
    output logic                       o_first_clock_phase,  // Phase one
    output logic                       o_second_clock_phase, // Phase two
    output logic [IRQ_N-1:0]           o_irq_pending, // Pending requests
    output logic                       o_irq_ack_n,   // Ack strobe, low
    output logic                       o_vec_fetch,   // Vector fetch pulse
    output logic [2:0]                 o_vec_wait_states, // Fetch waits
    output logic                       o_boot_done,   // Vector fetches done
    output logic [2:0]                 o_bus_wait_states, // Bus control
    output logic [ASYNC_N-1:0]         o_async_oe,    // Gated pin enables
    output logic [RW_N-1:0]            o_rw_oe,       // Gated dir enables
    output logic                       o_rst_n        // Synced reset
);

    ////////////////////////////////////////////////////////////////////
    // Reset release synchroniser

    logic rst_s1_q;
    logic rst_n_q;

    // Release passes two flops; assertion is immediate
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1; // RULE1
            rst_n_q  <= rst_s1_q;
        end
    end

    assign o_rst_n = rst_n_q;

    ////////////////////////////////////////////////////////////////////
    // Internal clock phases

    logic ph1_q;
    wire  ph1_fall = i_ce & ph1_q;  // Phase one about to fall
    wire  ph1_rise = i_ce & ~ph1_q; // Phase one about to rise

    // Phase one toggles every enabled cycle
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ph1_q <= 1'b0;
        end else if (i_ce) begin
            ph1_q <= ~ph1_q;
        end
    end

    assign o_first_clock_phase  = ph1_q;
    assign o_second_clock_phase = ~ph1_q;

    ////////////////////////////////////////////////////////////////////
    // Pin floating during reset

    wire run = i_arst_n & rst_n_q; // Low at once when pin falls

    // Enables drop combinationally with the reset pin
    assign o_async_oe = i_async_oe_req & {ASYNC_N{run}}; // RULE4 RULE5
    assign o_rw_oe    = i_rw_oe_req & {RW_N{run}};       // RULE6

    ////////////////////////////////////////////////////////////////////
    // Bus control wait states

    logic [2:0] bus_ws_q;

    // Reset forces the slow setting until rewritten
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bus_ws_q <= reset_irq_pkg::WS_RESET; // RULE7
        end else if (i_ce && i_bus_ws_wr) begin
            bus_ws_q <= i_bus_ws_data;
        end
    end

    assign o_bus_wait_states = bus_ws_q;

    ////////////////////////////////////////////////////////////////////
    // Reset vector fetch sequencer

    logic mode_s1_q;
    logic mode_s2_q;

    // Strap pin crosses two flops; no reset, so it settles during reset
    always_ff @(posedge i_ref_clk) begin
        if (i_ce) begin
            mode_s1_q <= i_mcu_mode;
            mode_s2_q <= mode_s1_q;
        end
    end

    reset_irq_pkg::boot_state_type state_q;
    reset_irq_pkg::boot_state_type state_d;
    logic [2:0] vws_q;
    logic [2:0] ws_cnt_q;
    logic [1:0] fetch_cnt_q;

    wire fetch_end = (state_q == reset_irq_pkg::BOOT_FETCH &&
                      vws_q == 3'h0) ||
                     (state_q == reset_irq_pkg::BOOT_WAIT &&
                      ws_cnt_q == 3'h1);
    wire last_fetch = fetch_cnt_q == reset_irq_pkg::VEC_FETCHES - 2'h1;

    // Next state of the sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            reset_irq_pkg::BOOT_HOLD: begin
                state_d = reset_irq_pkg::BOOT_FETCH;
            end
            reset_irq_pkg::BOOT_FETCH,
            reset_irq_pkg::BOOT_WAIT: begin
                if (fetch_end) begin
                    state_d = last_fetch ? reset_irq_pkg::BOOT_RUN
                                         : reset_irq_pkg::BOOT_FETCH;
                end else begin
                    state_d = reset_irq_pkg::BOOT_WAIT;
                end
            end
            reset_irq_pkg::BOOT_RUN: begin
                state_d = reset_irq_pkg::BOOT_RUN;
            end
            default: begin
                state_d = reset_irq_pkg::BOOT_HOLD;
            end
        endcase
    end

    // Strap caught after release; fetches counted with their waits
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q     <= reset_irq_pkg::BOOT_HOLD;
            vws_q       <= reset_irq_pkg::WS_RESET;
            ws_cnt_q    <= 3'h0;
            fetch_cnt_q <= 2'h0;
        end else if (i_ce) begin
            state_q <= state_d;
            if (state_q == reset_irq_pkg::BOOT_HOLD) begin
                vws_q <= mode_s2_q ? reset_irq_pkg::WS_MCU   // RULE3
                                   : reset_irq_pkg::WS_RESET; // RULE2
            end
            if (state_q == reset_irq_pkg::BOOT_FETCH) begin
                ws_cnt_q <= vws_q;
            end else if (state_q == reset_irq_pkg::BOOT_WAIT) begin
                ws_cnt_q <= ws_cnt_q - 3'h1;
            end
            if (fetch_end) begin
                fetch_cnt_q <= fetch_cnt_q + 2'h1; // RULE2 RULE3
            end
        end
    end

    assign o_vec_fetch = state_q == reset_irq_pkg::BOOT_FETCH;
    assign o_vec_wait_states = vws_q;
    assign o_boot_done = state_q == reset_irq_pkg::BOOT_RUN;

    ////////////////////////////////////////////////////////////////////
    // Request synchroniser, detection and pending flags

    logic [IRQ_N-1:0] irq_s1_q;
    logic [IRQ_N-1:0] irq_s2_q;
    logic [IRQ_N-1:0] pend_q;

    // Low level sampled only as phase one falls
    wire [IRQ_N-1:0] irq_det = ~irq_s2_q & {IRQ_N{ph1_fall}}; // RULE8 RULE9
    // Taking is honoured only at a fetch boundary
    wire [IRQ_N-1:0] irq_clr =
        (i_take.cpu_take & {IRQ_N{i_take.cpu_fetch}}) |
        (i_take.dma_take & {IRQ_N{i_take.dma_fetch}}); // RULE10

    // Pins cross through two flops before detection
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_s1_q <= {IRQ_N{1'b1}};
            irq_s2_q <= {IRQ_N{1'b1}};
            pend_q   <= {IRQ_N{1'b0}};
        end else if (i_ce) begin
            irq_s1_q <= i_ext_irq_n; // RULE13
            irq_s2_q <= irq_s1_q;
            pend_q   <= (pend_q & ~irq_clr) | irq_det; // RULE12 RULE16
        end
    end

    assign o_irq_pending = pend_q;

    ////////////////////////////////////////////////////////////////////
    // Acknowledge strobe

    logic ack_arm_q;
    logic ack_n_q;
    logic dec_prev_q;
    wire  dec_new = i_ack_decode & ~dec_prev_q; // Decode start only

    // Decode start waits for the next phase one rise; a stretched
    // decode does not stretch the strobe
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_arm_q  <= 1'b0;
            ack_n_q    <= 1'b1;
            dec_prev_q <= 1'b0;
        end else if (i_ce) begin
            dec_prev_q <= i_ack_decode;
            if (ph1_rise) begin
                ack_n_q   <= ~ack_arm_q & ~dec_new; // RULE14 RULE15
                ack_arm_q <= 1'b0;
            end else if (dec_new) begin
                ack_arm_q <= 1'b1;
            end
        end
    end

    assign o_irq_ack_n = ack_n_q;

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic [2:0] fetch_seen_q;

    // Counts vector fetch pulses since reset
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fetch_seen_q <= 3'h0;
        end else if (i_ce && o_vec_fetch) begin
            fetch_seen_q <= fetch_seen_q + 3'h1;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n_q || !i_ce);

    sequence ack_open_s;
        $fell(ack_n_q) && ph1_q;
    endsequence

    sequence ack_hold_s;
        ##1 !ack_n_q ##1 ack_n_q;
    endsequence

    ack_open_a: assert property ( // RULE14
        $fell(ack_n_q) |-> ack_open_s
    ) else $error("Ack strobe fell off phase one rise");

    ack_width_a: assert property ( // RULE15
        ack_open_s |-> ack_hold_s
    ) else $error("Ack strobe low other than one cycle");

    ack_close_a: assert property ( // RULE14
        $rose(ack_n_q) |-> ph1_q
    ) else $error("Ack strobe rose off phase one rise");

    irq_detect_a: assert property ( // RULE9
        (ph1_q && !irq_s2_q[0]) |=> pend_q[0]
    ) else $error("Low request at phase fall not pended");

    irq_phase_a: assert property ( // RULE8
        $rose(pend_q[0]) |-> !ph1_q && !$past(irq_s2_q[0])
    ) else $error("Request pended off phase fall or on high");

    irq_take_a: assert property ( // RULE10
        $fell(pend_q[0]) |-> $past(irq_clr[0])
    ) else $error("Pending flag cleared without fetch take");

    vec_slow_a: assert property ( // RULE2
        (o_vec_fetch && vws_q == 3'h7) |=> !o_vec_fetch [*7]
    ) else $error("Processor mode fetch shorter than seven waits");

    vec_count_a: assert property ( // RULE3
        o_boot_done |-> fetch_seen_q == 3'h2
    ) else $error("Vector not fetched exactly twice");

    bus_ws_a: assert property ( // RULE7
        $rose(rst_n_q) |-> bus_ws_q == 3'h7
    ) else $error("Bus wait states not seven after reset");

    pin_float_a: assert property ( // RULE5
        disable iff (1'b0) !rst_n_q |-> o_async_oe == '0 && o_rw_oe == '0
    ) else $error("Pins driven during reset");

endmodule : reset_irq_ack

`default_nettype wire

//--- reset_irq_pkg.sv
// Shared constants and types for the reset, interrupt and acknowledge block
package reset_irq_pkg;

    // Line counts
    localparam int IRQ_LINES   = 4;   // External request lines
    localparam int ASYNC_PINS  = 10;  // Flag, serial and timer pins
    localparam int RW_PINS     = 1;   // Read/write direction outputs

    // Wait-state figures
    localparam logic [2:0] WS_RESET   = 3'h7; // Slow default after reset
    localparam logic [2:0] WS_MCU     = 3'h0; // Vector fetch, on-chip boot
    localparam logic [1:0] VEC_FETCHES = 2'h2; // Reset vector fetch count

    // Clock figures
    localparam int CLK_PERIOD_NS = 10;  // Reference clock period
    localparam int ACK_LOW_NS    = 20;  // One instruction cycle
    localparam int ACK_LOW_CYC   = (ACK_LOW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    // Boot sequencer states
    typedef enum logic [1:0] {
        BOOT_HOLD,
        BOOT_FETCH,
        BOOT_WAIT,
        BOOT_RUN
    } boot_state_type;

    // Interrupt take request from core and DMA
    typedef struct packed {
        logic                 cpu_fetch; // Core at a fetch boundary
        logic [IRQ_LINES-1:0] cpu_take;  // Lines the core takes
        logic                 dma_fetch; // DMA at a fetch boundary
        logic [IRQ_LINES-1:0] dma_take;  // Lines the DMA takes
    } take_type;

endpackage : reset_irq_pkg

//--- irq_source.sv
// Model of an external device raising interrupt requests
`timescale 1ns/10ps
`default_nettype none
module irq_source (
    input  wire logic       i_ref_clk, // Bench clock
    input  wire logic [1:0] i_line,    // Line to pull low
    input  wire logic [2:0] i_len,     // Cycles held low
    input  wire logic       i_go,      // Start a request
    output var  logic [3:0] o_irq_n    // Request pins, active low
);
    int cnt = 0;
    initial o_irq_n = 4'hF;
    // Count the hold time from the start request
    always @(posedge i_ref_clk) begin
        if (i_go)
            cnt <= i_len;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Hold one line low for i_len cycles, others idle high
    always @(negedge i_ref_clk) begin
        o_irq_n <= (cnt > 0) ? ~(4'h1 << i_line) : 4'hF;
    end
endmodule : irq_source
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the reset, interrupt and acknowledge block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic                     clk     = 1'b0;
    logic                     arst_n  = 1'b0;
    logic                     mcu     = 1'b0;
    logic                     decode  = 1'b0;
    logic                     ws_wr   = 1'b0;
    logic [2:0]               ws_data = 3'h0;
    logic [9:0]               oe_req  = 10'h3FF;
    logic [0:0]               rw_req  = 1'h1;
    reset_irq_pkg::take_type  take    = '0;
    logic [1:0]               line    = 2'h0;
    logic                     go      = 1'b0;
    logic [31:0]              seed    = 32'h71D2;
    logic                     ce      = 1'b1;
    logic [2:0]               len     = 3'h3;
    int                       n_errors   = 0;
    int                       num_checks = 0;
    wire logic [3:0]          irq_n;
    wire logic [3:0]          pend;
    wire logic [2:0]          vws;
    wire logic [2:0]          bws;
    wire logic [9:0]          aoe;
    wire logic [0:0]          rwoe;
    wire logic                ack_n;
    wire logic                vfetch;
    wire logic                done;
    wire logic                ph1;
    wire logic                ph2;
    wire logic                rstn;
    always #5 clk = ~clk;
    reset_irq_ack reset_irq_ack_i (.i_ref_clk(clk), .i_arst_n(arst_n),
        .i_ce(ce), .i_mcu_mode(mcu), .i_ext_irq_n(irq_n), .i_take(take),
        .i_ack_decode(decode), .i_bus_ws_wr(ws_wr), .i_bus_ws_data(ws_data),
        .i_async_oe_req(oe_req), .i_rw_oe_req(rw_req),
        .o_first_clock_phase(ph1), .o_second_clock_phase(ph2),
        .o_irq_pending(pend), .o_irq_ack_n(ack_n), .o_vec_fetch(vfetch),
        .o_vec_wait_states(vws), .o_boot_done(done),
        .o_bus_wait_states(bws), .o_async_oe(aoe), .o_rw_oe(rwoe),
        .o_rst_n(rstn));
    irq_source irq_source_i (.i_ref_clk(clk), .i_line(line), .i_len(len),
        .i_go(go), .o_irq_n(irq_n));
    ////////////////////////////////////////////////////////////////////////
    // Random source and expectations
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [2:0] boot_ws(input logic m);
        return m ? reset_irq_pkg::WS_MCU : reset_irq_pkg::WS_RESET;
    endfunction : boot_ws
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    // Reset with pins floated, then the two vector fetches
    task automatic reset_boot(input logic m);
        int k;
        int nf;
        int t0;
        logic [2:0] w;
        arst_n = 1'b0;
        mcu = m;
        oe_req = 10'h3FF;
        @(negedge clk);
        check("async_oe", 0, aoe);
        check("rw_oe", 0, rwoe);
        check("bus_ws", reset_irq_pkg::WS_RESET, bws);
        check("ack_idle", 1, ack_n);
        check("rst_sync", 0, rstn);
        repeat (9) @(negedge clk);
        arst_n = 1'b1;
        nf = 0;
        t0 = 0;
        w = 3'h0;
        for (k = 0; k < 40 && done !== 1'b1; k++) begin
            @(negedge clk);
            if (vfetch === 1'b1) begin
                if (nf == 0)
                    t0 = k;
                nf++;
                w = vws;
            end
        end
        check("boot_done", 1, done);
        check("fetches", reset_irq_pkg::VEC_FETCHES, nf);
        check("vec_ws", boot_ws(m), w);
        check("boot_span", 2 * (1 + boot_ws(m)), k - 1 - t0);
        oe_req = 10'(rnd());
        @(negedge clk);
        check("async_oe_run", oe_req, aoe);
        check("rw_oe_run", rw_req, rwoe);
        check("rst_sync_run", 1, rstn);
        $display("test boot mode %0d done", m);
    endtask : reset_boot
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int i;
        int k;
        int nl;
        int n;
        int hold;
        logic p;
        logic ph_at;
        logic [2:0] wsv;
        reset_boot(1'b0);
        for (i = 0; i < 8; i++) begin
            line = 2'(rnd());
            len = 3'(2 + rnd() % 3);
            go = 1'b1;
            @(negedge clk);
            go = 1'b0;
            for (k = 0; k < 8 && pend[line] !== 1'b1; k++)
                @(negedge clk);
            check("irq_pending", 1, pend[line]);
            repeat (6) @(negedge clk);
            take.cpu_take = 4'h1 << line;
            take.dma_take = 4'h1 << line;
            @(negedge clk);
            check("take_no_fetch", 1, pend[line]);
            take.cpu_fetch = ~i[0];
            take.dma_fetch = i[0];
            @(negedge clk);
            take = '0;
            check("take_clear", 0, pend);
        end
        // Long request, taken at every fetch: re-accepted each phase
        @(negedge clk);
        line = 2'(rnd());
        len = 3'h7;
        take.cpu_fetch = 1'b1;
        take.cpu_take = 4'h1 << line;
        go = 1'b1;
        n = 0;
        for (k = 0; k < 14; k++) begin
            @(negedge clk);
            go = 1'b0;
            if (pend[line] === 1'b1)
                n++;
        end
        take = '0;
        check("irq_repeat", 1, n == 3 || n == 4);
        $display("test interrupts done");
        // Decode held one to three cycles: strobe width stays fixed
        for (i = 0; i < 6; i++) begin
            repeat (rnd() % 3) @(negedge clk);
            hold = 1 + i % 3;
            decode = 1'b1;
            nl = 0;
            ph_at = 1'b0;
            for (k = 0; k < 8; k++) begin
                @(negedge clk);
                if (k == hold - 1)
                    decode = 1'b0;
                if (ack_n === 1'b0 && nl == 0)
                    ph_at = ph1;
                if (ack_n === 1'b0)
                    nl++;
            end
            check("ack_low", reset_irq_pkg::ACK_LOW_CYC, nl);
            check("ack_phase", 1, ph_at);
        end
        $display("test acknowledge done");
        ws_wr = 1'b1;
        for (i = 0; i < 4; i++) begin
            ws_data = 3'(rnd());
            @(negedge clk);
            check("bus_ws_write", ws_data, bws);
        end
        // Enable low freezes the phase and refuses the write
        wsv = ws_data;
        p = ph1;
        ce = 1'b0;
        ws_data = ~wsv;
        repeat (3) @(negedge clk);
        check("ce_phase", p, ph1);
        check("ce_ws", wsv, bws);
        ce = 1'b1;
        ws_wr = 1'b0;
        @(negedge clk);
        check("run_phase", !p, ph1);
        check("phase_two", !ph1, ph2);
        $display("test wait states done");
        reset_boot(1'b1);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
